// *** rtl/ofl_limiter.sv ***
// output frequency limiter: clamps, jump bands, jog and stall priority
`default_nettype none
`include "ofl_defines.svh"
module ofl_limiter import ofl_pkg::*; #(
  parameter int NBANDS = 3
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic [3:0] user_group_read_select_i,
  input wire ofl_wr_t wr_i,
  input wire logic wr_valid_i,
  input wire ofl_ctl_t ctl_i,
  input wire logic [15:0] cmd_freq_i,
  input wire logic [15:0] stall_freq_i,
  output logic wr_refused_o,
  output logic [15:0] out_freq_o,
  output logic ramping_o,
  output logic [15:0] upper_freq_limit_o
);
  initial begin
    if (NBANDS != 3) $error("ofl_limiter: three jump bands only");
  end

  ////////////////////////////////////////////////////////////////////////////
  // parameter store
  logic accept_wr;
  logic [11*16-1:0] words;
  ofl_freq_t upper_freq_limit, lower_freq_limit, high_speed_upper_limit;
  ofl_freq_t jog_setpoint, starting_freq_setting;

  // writes only when the group selector is zero and the value is in range
  function automatic logic in_range(input logic [3:0] id, input logic [15:0] v);
    if (id == `OFL_ID_UPPER || id == `OFL_ID_LOWER) in_range = (v <= `OFL_F_120HZ);
    else if (id == `OFL_ID_HS)
      in_range = (v >= `OFL_F_120HZ) && (v <= `OFL_F_400HZ); // RULE_02
    else if (id >= `OFL_ID_J1A && id <= `OFL_ID_J3B)
      in_range = (v <= `OFL_F_400HZ) || (v == `OFL_JUMP_OFF); // RULE_08
    else in_range = (id <= `OFL_ID_J3B) && (v <= `OFL_F_400HZ);
  endfunction

  assign accept_wr = wr_valid_i && (user_group_read_select_i == 4'h0) // RULE_10
                     && in_range(wr_i.id, wr_i.value);
  assign wr_refused_o = wr_valid_i && !accept_wr;

  ofl_param_mem #(.DEPTH(11)) u_mem (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .ce_i(ce_i),
    .we_i(accept_wr),
    .waddr_i(wr_i.id),
    .wdata_i(wr_i.value),
    .words_o(words)
  );

  assign upper_freq_limit = words[0*16 +: 16];
  assign lower_freq_limit = words[1*16 +: 16];
  assign high_speed_upper_limit = words[2*16 +: 16];
  assign jog_setpoint = words[3*16 +: 16];
  assign starting_freq_setting = words[4*16 +: 16];
  assign upper_freq_limit_o = upper_freq_limit;

  ////////////////////////////////////////////////////////////////////////////
  // target computation
  ofl_freq_t ceiling, target, clamped, jumped;

  // a jump band is live only when both edges are set
  function automatic logic band_on(input logic [15:0] a, input logic [15:0] b);
    band_on = (a != `OFL_JUMP_OFF) && (b != `OFL_JUMP_OFF);
  endfunction

  // the high speed ceiling governs once it is above 120 Hz
  always_comb begin
    ceiling = (high_speed_upper_limit > `OFL_F_120HZ) ? high_speed_upper_limit // RULE_02
              : upper_freq_limit;
  end

  // clamp then jump; jog at or under the lower limit escapes the floor
  always_comb begin
    logic [15:0] lo, hi, a, b;
    lo = '0;
    hi = '0;
    a = '0;
    b = '0;
    if (ctl_i.jog) begin
      target = jog_setpoint;
    end else if (ctl_i.cmd_valid) begin
      target = cmd_freq_i;
    end else begin
      target = `OFL_F_0HZ; // bare start: floor lifts it to the lower limit
    end
    clamped = target;
    if (clamped > ceiling) clamped = ceiling; // RULE_01
    if (clamped < lower_freq_limit && !(ctl_i.jog && jog_setpoint <= lower_freq_limit))
      clamped = lower_freq_limit; // RULE_04 RULE_05 RULE_07
    jumped = clamped;
    for (int k = 0; k < NBANDS; k++) begin
      a = words[(5 + 2*k)*16 +: 16];
      b = words[(6 + 2*k)*16 +: 16];
      lo = (a < b) ? a : b;
      hi = (a < b) ? b : a;
      // hold at the lower edge so the motor never settles inside
      if (band_on(a, b) && jumped > lo && jumped < hi) jumped = lo; // RULE_12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ramp toward the steady setpoint
  ofl_state_t state, next_state;
  ofl_freq_t next_out;
  logic run;
  assign run = ctl_i.start || ctl_i.jog;

  // ramp walks through bands unaffected; only the endpoint is jumped
  always_comb begin
    next_state = state;
    next_out = out_freq_o;
    case (state)
      OFL_IDLE: begin
        next_out = `OFL_F_0HZ;
        if (run) begin
          next_state = OFL_RAMP;
          next_out = (starting_freq_setting < jumped) ? starting_freq_setting : jumped;
        end
      end
      OFL_RAMP, OFL_STEADY: begin
        if (!run) begin
          if (out_freq_o <= `OFL_RAMP_STEP) begin
            next_out = `OFL_F_0HZ;
            next_state = OFL_IDLE;
          end else begin
            next_out = out_freq_o - `OFL_RAMP_STEP;
            next_state = OFL_RAMP;
          end
        end else if (out_freq_o < jumped) begin
          next_out = out_freq_o + `OFL_RAMP_STEP; // RULE_07 RULE_09
          next_state = OFL_RAMP;
        end else if (out_freq_o > jumped) begin
          next_out = out_freq_o - `OFL_RAMP_STEP; // RULE_09
          next_state = OFL_RAMP;
        end else begin
          next_state = OFL_STEADY;
        end
        // stall reduction overrides; floor not applied here
        if (run && ctl_i.stall && stall_freq_i < next_out) begin
          next_out = stall_freq_i; // RULE_06
          next_state = OFL_RAMP;
        end
      end
      default: begin
        next_state = OFL_IDLE;
        next_out = `OFL_F_0HZ;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= OFL_IDLE;
      out_freq_o <= `OFL_F_0HZ;
    end else if (ce_i) begin
      state <= next_state;
      out_freq_o <= next_out;
    end
  end
  assign ramping_o = (state == OFL_RAMP);

  ////////////////////////////////////////////////////////////////////////////
  // checks
  steady_ceiling_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_01
    (state == OFL_STEADY && !ctl_i.stall) |-> out_freq_o <= ceiling)
    else $error("steady output above ceiling");
  steady_floor_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_04
    (state == OFL_STEADY && !ctl_i.jog && !ctl_i.stall) |-> out_freq_o >= lower_freq_limit)
    else $error("steady output below lower limit");
  hs_copy_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_03
    (ce_i && accept_wr && wr_i.id == `OFL_ID_HS) |-> ##2 (upper_freq_limit == $past(wr_i.value, 2)))
    else $error("high speed write not copied");
  lock_write_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_10
    (wr_valid_i && user_group_read_select_i != 4'h0) |-> wr_refused_o)
    else $error("write taken while group select nonzero");
  ramp_step_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_09
    (ce_i && state == OFL_RAMP && run && !ctl_i.stall && out_freq_o < jumped)
    |=> out_freq_o == $past(out_freq_o) + `OFL_RAMP_STEP)
    else $error("ramp skipped frequencies");
  stall_pass_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_06
    (ce_i && state != OFL_IDLE && run && ctl_i.stall && stall_freq_i < next_out)
    |=> out_freq_o == $past(stall_freq_i))
    else $error("stall reduction blocked");
  jog_wins_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_05
    (ctl_i.jog && jog_setpoint <= lower_freq_limit && jog_setpoint <= ceiling) |-> clamped == jog_setpoint)
    else $error("jog setpoint not given priority");
  bare_start_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_07
    (ctl_i.start && !ctl_i.cmd_valid && !ctl_i.jog) |-> clamped == lower_freq_limit)
    else $error("bare start not aimed at lower limit");
  hs_range_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_02
    (wr_valid_i && wr_i.id == `OFL_ID_HS && wr_i.value > `OFL_F_400HZ) |-> wr_refused_o)
    else $error("high speed limit out of range taken");
  band_edge_a: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RULE_12
    (band_on(words[5*16 +: 16], words[6*16 +: 16]) && words[5*16 +: 16] < words[6*16 +: 16])
    |-> !(jumped > words[5*16 +: 16] && jumped < words[6*16 +: 16]))
    else $error("setpoint inside band one");
  reach_steady_c: cover property (@(posedge clock_i) state == OFL_RAMP ##1 state == OFL_STEADY);
  stall_c: cover property (@(posedge clock_i) ctl_i.stall && state == OFL_RAMP);
  refused_c: cover property (@(posedge clock_i) wr_refused_o);
  jog_c: cover property (@(posedge clock_i) ctl_i.jog && state == OFL_STEADY);
endmodule
`default_nettype wire

// *** common/ofl_defines.svh ***
// constants for the output frequency limiter
// Function
// RULE_01: command above upper limit outputs upper limit; the code clamps to the high speed limit instead whenever that is above 120 Hz
// RULE_02: high speed ceiling allows 120 to 400 Hz
// RULE_03: writing high speed limit copies into upper
// RULE_04: below lower limit output holds lower limit
// RULE_05: jog at or below lower limit wins
// RULE_06: stall reduction may go below lower limit
// RULE_07: bare start accelerates to lower limit
// RULE_08: three jump bands, 9999 disables each band
// RULE_09: ramping passes through jump bands normally
// RULE_10: settings writable only when group select zero
// RULE_11: analog gain must rise above 60 Hz; the limiter has no analog input or gain stage
// RULE_12: steady setpoint in band holds band edge
`ifndef OFL_DEFINES_SVH
`define OFL_DEFINES_SVH
// frequencies in units of 0.01 Hz
`define OFL_FREQ_W 16
`define OFL_F_120HZ 16'h2ee0
`define OFL_F_400HZ 16'h9c40
`define OFL_F_0HZ 16'h0000
`define OFL_JUMP_OFF 16'h270f
`define OFL_UPPER_RST 16'h2ee0
`define OFL_LOWER_RST 16'h0000
`define OFL_HS_RST 16'h2ee0
`define OFL_SEL_W 4
`define OFL_ID_UPPER 4'h0
`define OFL_ID_LOWER 4'h1
`define OFL_ID_HS 4'h2
`define OFL_ID_JOG 4'h3
`define OFL_ID_START 4'h4
`define OFL_ID_J1A 4'h5
`define OFL_ID_J3B 4'ha
`define OFL_JOG_RST 16'h01f4
`define OFL_START_RST 16'h0032
`define OFL_RAMP_STEP 16'h0001
`endif

// *** common/ofl_pkg.sv ***
// types for the output frequency limiter
`default_nettype none
package ofl_pkg;
  typedef logic [15:0] ofl_freq_t;
  typedef struct packed {
    logic [3:0] id;
    logic [15:0] value;
  } ofl_wr_t;
  typedef struct packed {
    logic start;
    logic jog;
    logic stall;
    logic cmd_valid;
  } ofl_ctl_t;
  typedef enum logic [1:0] {
    OFL_IDLE = 2'b00,
    OFL_RAMP = 2'b01,
    OFL_STEADY = 2'b10
  } ofl_state_t;
endpackage
`default_nettype wire

// *** rtl/ofl_param_mem.sv ***
// small parameter store holding the setting words
`default_nettype none
`include "ofl_defines.svh"
module ofl_param_mem import ofl_pkg::*; #(
  parameter int DEPTH = 11
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [3:0] waddr_i,
  input wire logic [15:0] wdata_i,
  output logic [DEPTH*16-1:0] words_o
);
  initial begin
    if (DEPTH != 11) $error("ofl_param_mem: depth must be 11");
  end
  logic [15:0] mem [DEPTH];
  logic [15:0] next_mem [DEPTH];
  // reset defaults per word; jump words start disabled
  function automatic logic [15:0] rst_val(input int i);
    case (i)
      0: rst_val = `OFL_UPPER_RST;
      1: rst_val = `OFL_LOWER_RST;
      2: rst_val = `OFL_HS_RST;
      3: rst_val = `OFL_JOG_RST;
      4: rst_val = `OFL_START_RST;
      default: rst_val = `OFL_JUMP_OFF; // RULE_08
    endcase
  endfunction
  // write port; a high speed write also lands in the upper limit word
  always_comb begin
    for (int i = 0; i < DEPTH; i++) next_mem[i] = mem[i];
    if (we_i && (int'(waddr_i) < DEPTH)) begin
      next_mem[waddr_i] = wdata_i;
      if (waddr_i == `OFL_ID_HS) next_mem[`OFL_ID_UPPER] = wdata_i; // RULE_03
    end
  end
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= rst_val(i);
    end else if (ce_i) begin
      for (int i = 0; i < DEPTH; i++) mem[i] <= next_mem[i];
    end
  end
  // registered read bus
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      words_o <= '0;
    end else if (ce_i) begin
      for (int i = 0; i < DEPTH; i++) words_o[i*16 +: 16] <= mem[i];
    end
  end
endmodule
`default_nettype wire

// *** sim/ofl_gen_model.sv ***
// behavioural model of the output frequency generator fed by the limiter
`default_nettype none
module ofl_gen_model (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [15:0] freq_i,
  output logic [31:0] phase_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // phase advances by the commanded frequency each cycle; it wraps freely like a real nco,
  // so a zero output frequency shows up as a phase that no longer moves
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_o <= 32'h0000_0000;
    end else begin
      phase_o <= phase_o + {16'h0000, freq_i};
    end
  end
endmodule
`default_nettype wire

// *** sim/output_frequency_limiter_tb.sv ***
// self-checking testbench for the output frequency limiter
`default_nettype none
module output_frequency_limiter_tb import ofl_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic [3:0] sel = 4'h0;
  ofl_wr_t wr = '0;
  logic wr_valid = 1'b0;
  ofl_ctl_t ctl = '0;
  logic [15:0] cmd = 16'h0000;
  logic [15:0] stall_freq = 16'h0000;
  logic refused;
  logic [15:0] out_freq;
  logic ramping;
  logic [15:0] upper;
  logic [31:0] phase;
  logic seen_mid = 1'b0;
  logic [15:0] hold;
  int n_mismatch = 0;
  int n_compared = 0;
  logic [19:0] bad [5] = '{{4'h0, 16'h2ee1}, {4'h2, 16'h2edf}, {4'h2, 16'h9c41},
                           {4'h5, 16'h9c41}, {4'hb, 16'h0000}};

  always #5 clock_i = ~clock_i;

  ofl_limiter uut (.clock_i(clock_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
    .user_group_read_select_i(sel), .wr_i(wr), .wr_valid_i(wr_valid), .ctl_i(ctl),
    .cmd_freq_i(cmd), .stall_freq_i(stall_freq), .wr_refused_o(refused),
    .out_freq_o(out_freq), .ramping_o(ramping), .upper_freq_limit_o(upper));

  ofl_gen_model gen (.clock_i(clock_i), .arst_n_i(arst_n_i), .freq_i(out_freq), .phase_o(phase));

  // remembers whether the ramp out of the band edge crossed the middle of the first band;
  // only the 0xb0 leg counts, since the first ramp passes 0x80 before any band is live
  always @(posedge clock_i) begin
    if (ramping === 1'b1 && out_freq === 16'h0080 && cmd === 16'h00b0) seen_mid <= 1'b1;
  end

  task automatic stop_test();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write cycle; the refused flag is combinational so it is read in the same cycle
  task automatic wr_set(input logic [3:0] s, input logic [3:0] id, input logic [15:0] v,
                        input logic exp);
    @(posedge clock_i);
    sel <= s;
    wr <= '{id: id, value: v};
    wr_valid <= 1'b1;
    #1 chk({15'h0000, refused}, {15'h0000, exp});
    @(posedge clock_i);
    wr_valid <= 1'b0;
    sel <= 4'h0;
  endtask

  // let new settings land, then wait for the ramp to finish and compare
  task automatic wait_steady(input logic [15:0] exp);
    int i;
    repeat (4) @(posedge clock_i);
    for (i = 0; i < 20000; i++) begin
      @(posedge clock_i);
      #1;
      if (ramping === 1'b0) break;
    end
    if (i == 20000) begin
      n_mismatch++;
      stop_test();
    end
    chk(out_freq, exp);
  endtask

  initial begin
    repeat (5) @(posedge clock_i);
    arst_n_i <= 1'b1;
    @(posedge clock_i);
    #1 chk(upper, 16'h2ee0);
    wr_set(4'h1, 4'h1, 16'h0010, 1'b1);
    for (int k = 0; k < 5; k++) wr_set(4'h0, bad[k][19:16], bad[k][15:0], 1'b1);
    wr_set(4'h0, 4'h0, 16'h0080, 1'b0);
    @(posedge clock_i);
    ctl <= '{start: 1'b1, jog: 1'b0, stall: 1'b0, cmd_valid: 1'b1};
    cmd <= 16'h0200; // command arrives digitally, so no analog gain step applies
    wait_steady(16'h0080);
    wr_set(4'h0, 4'h2, 16'h3000, 1'b0);
    repeat (2) @(posedge clock_i);
    #1 chk(upper, 16'h3000);
    // clock enable low must freeze the ramp in mid flight
    @(posedge clock_i);
    ce_i <= 1'b0;
    @(posedge clock_i);
    #1 hold = out_freq;
    repeat (3) @(posedge clock_i);
    #1 chk(out_freq, hold);
    @(posedge clock_i);
    ce_i <= 1'b1;
    wait_steady(16'h0200);
    wr_set(4'h0, 4'h1, 16'h0060, 1'b0);
    cmd <= 16'h0040;
    wait_steady(16'h0060);
    wr_set(4'h0, 4'h3, 16'h0050, 1'b0);
    ctl.jog <= 1'b1;
    wait_steady(16'h0050);
    @(posedge clock_i);
    ctl <= '{start: 1'b1, jog: 1'b0, stall: 1'b1, cmd_valid: 1'b0};
    stall_freq <= 16'h0020;
    repeat (2) @(posedge clock_i);
    #1 chk(out_freq, 16'h0020);
    ctl.stall <= 1'b0;
    wait_steady(16'h0060);
    wr_set(4'h0, 4'h5, 16'h0070, 1'b0);
    wr_set(4'h0, 4'h6, 16'h0090, 1'b0);
    wr_set(4'h0, 4'h7, 16'h270f, 1'b0);
    wr_set(4'h0, 4'h8, 16'h00b8, 1'b0);
    ctl.cmd_valid <= 1'b1;
    cmd <= 16'h0080;
    wait_steady(16'h0070);
    cmd <= 16'h00b0;
    wait_steady(16'h00b0);
    chk({15'h0000, seen_mid}, 16'h0001);
    ctl <= '0;
    wait_steady(16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
